// File: src/dcr_channel_regs.sv
// Channel configuration register bank with APB slave and field decode
// Operation
// - Bit 15 word 0 selects dual mode, resets 1
// - Programmable filter taps from center-tap field
// - Compensating filter taps; odd values for upconversion
// - Receive programmable gain 2^-19 to 2^-12
// - Transmit programmable gain uses lsb only
// - Compensating gain 2^-19 or 2^-18
// - Per-channel comb output left shift
// - Comb ratio is rate field plus one
// - Six comb sections delay 2 or 1
// - Coarse read address offset from write address
// - Fine delay three bits per channel
// - Fine adjust ratio 1 to 8, reset 1
// - Oscillator accumulators step by 32-bit word
// - Phase offset added to accumulator output
// - Dither enable from bit 15 word 0x19
// - Channel B settings other than the phase offset used only in dual mode
//
// Register access over APB is this design's own decision.
`default_nettype none
`include "dcr_regs.svh"

module dcr_channel_regs
    import dcr_pkg::*;
(
    input  wire logic        clk_sys,          // System clock, 100 MHz
    input  wire logic        rst_b,            // Async reset, active low
    input  wire logic        psel,             // APB select
    input  wire logic        penable,          // APB enable
    input  wire logic        pwrite,           // APB write direction
    input  wire logic [7:0]  paddr,            // APB byte address
    input  wire logic [31:0] pwdata,           // APB write data
    output logic             pready,           // APB ready
    output logic [31:0]      prdata,           // APB read data
    output logic             pslverr,          // APB error, unmapped address
    input  wire logic        is_upconverter,   // Channel is an upconverter
    input  wire logic        long_mode,        // Downconverter long filter mode
    input  wire logic [5:0]  coarse_wr_a,      // Coarse delay write address A
    input  wire logic [5:0]  coarse_wr_b,      // Coarse delay write address B
    output logic             dual_mode,        // Dual narrowband mode
    output logic             b_active,         // Channel B datapath in use
    output logic [8:0]       pfir_taps,        // Programmable filter tap count
    output logic [6:0]       cfir_taps,        // Compensating filter tap count
    output logic [4:0]       pfir_exp,         // Programmable scale is 2^-exp
    output logic [4:0]       cfir_exp,         // Compensating scale is 2^-exp
    output logic [4:0]       cic_shift_a,      // Comb output left shift A
    output logic [4:0]       cic_shift_b,      // Comb output left shift B
    output logic [5:0]       cic_ratio,        // Interpolation or decimation
    output logic [5:0]       comb_delay_double_first,  // Section delay 2 mask A
    output logic [5:0]       comb_delay_double_second, // Section delay 2 mask B
    output logic [5:0]       coarse_rd_a,      // Coarse delay read address A
    output logic [5:0]       coarse_rd_b,      // Coarse delay read address B
    output logic [2:0]       fine_dly_a,       // Fine delay in clocks A
    output logic [2:0]       fine_dly_b,       // Fine delay in clocks B
    output logic [3:0]       fine_ratio,       // Fine adjust ratio 1..8
    output logic [31:0]      acc_a,            // Phase accumulator A
    output logic [31:0]      acc_b,            // Phase accumulator B
    output logic [15:0]      phase_out_a,      // Phase to sinusoid gen A
    output logic [15:0]      phase_out_b,      // Phase to sinusoid gen B
    output logic             dither_en         // Oscillator phase dither on
);

    dcr_state_s st;
    dcr_state_s next_st;

    logic [7:0]  idx;
    logic        wr_ok;
    logic        setup;
    logic        mapped;
    logic [15:0] rd_word;
    logic [15:0] wd;

    // Register index from word-aligned byte address
    assign idx = {2'h0, paddr[7:2]};
    assign wd = pwdata[15:0];
    assign setup = psel && !penable;
    assign wr_ok = psel && penable && st.pready && pwrite;

    // Address decode and readback mux
    always_comb begin
        mapped = 1'b1;
        rd_word = 16'h0000;
        case (idx)
            `DCR_IDX_MODE_TAP: begin
                rd_word[`DCR_POS_DUAL] = st.f.dual_mode;
                rd_word[`DCR_POS_PFIR_CTR +: 5] = st.f.pfir_ctr;
                rd_word[`DCR_POS_CFIR_CTR +: 5] = st.f.cfir_ctr;
            end
            `DCR_IDX_FILT_GAIN: begin
                rd_word[`DCR_POS_PFIR_GAIN +: 3] = st.f.pfir_gain;
                rd_word[`DCR_POS_CFIR_GAIN] = st.f.cfir_gain;
            end
            `DCR_IDX_COMB_SHIFT: begin
                rd_word[`DCR_POS_SHIFT_A +: 5] = st.f.shift_a;
                rd_word[`DCR_POS_SHIFT_B +: 5] = st.f.shift_b;
                rd_word[`DCR_POS_RATE +: 5] = st.f.rate;
            end
            `DCR_IDX_COMB_DELAY: begin
                rd_word[`DCR_POS_DLY_FIRST +: 6] = st.f.dly_first;
                rd_word[`DCR_POS_DLY_SECOND +: 6] = st.f.dly_second;
            end
            `DCR_IDX_COARSE: begin
                rd_word[`DCR_POS_COARSE_A +: 6] = st.f.coarse_a;
                rd_word[`DCR_POS_COARSE_B +: 6] = st.f.coarse_b;
            end
            `DCR_IDX_FINE: begin
                rd_word[`DCR_POS_FINE_A +: 3] = st.f.fine_a;
                rd_word[`DCR_POS_FINE_B +: 3] = st.f.fine_b;
                rd_word[`DCR_POS_FINE_RATIO +: 3] = st.f.fine_ratio;
            end
            `DCR_IDX_FREQ_A_LO: rd_word = st.f.freq_a_lo;
            `DCR_IDX_FREQ_A_HI: rd_word = st.f.freq_a_hi;
            `DCR_IDX_FREQ_B_LO: rd_word = st.f.freq_b_lo;
            `DCR_IDX_FREQ_B_HI: rd_word = st.f.freq_b_hi;
            `DCR_IDX_PHASE_A:   rd_word = st.f.phase_a;
            `DCR_IDX_PHASE_B:   rd_word = st.f.phase_b;
            `DCR_IDX_MISC: begin
                rd_word[`DCR_POS_DITHER] = st.f.dither;
            end
            default: begin
                mapped = 1'b0;
            end
        endcase
    end

    // Next state: bus handshake, field writes, decoded controls
    always_comb begin
        next_st = st;

        // Ready and read data prepared in the setup cycle
        next_st.pready = setup;
        next_st.pslverr = setup && !mapped;
        next_st.prdata = (setup && !pwrite) ? {16'h0000, rd_word} : 32'h0000_0000;

        // Field writes at the access edge; unmapped writes are dropped
        if (wr_ok) begin
            case (idx)
                `DCR_IDX_MODE_TAP: begin
                    next_st.f.dual_mode = wd[`DCR_POS_DUAL];
                    next_st.f.pfir_ctr = wd[`DCR_POS_PFIR_CTR +: 5];
                    next_st.f.cfir_ctr = wd[`DCR_POS_CFIR_CTR +: 5];
                end
                `DCR_IDX_FILT_GAIN: begin
                    next_st.f.pfir_gain = wd[`DCR_POS_PFIR_GAIN +: 3];
                    next_st.f.cfir_gain = wd[`DCR_POS_CFIR_GAIN];
                end
                `DCR_IDX_COMB_SHIFT: begin
                    next_st.f.shift_a = wd[`DCR_POS_SHIFT_A +: 5];
                    next_st.f.shift_b = wd[`DCR_POS_SHIFT_B +: 5];
                    next_st.f.rate = wd[`DCR_POS_RATE +: 5];
                end
                `DCR_IDX_COMB_DELAY: begin
                    next_st.f.dly_first = wd[`DCR_POS_DLY_FIRST +: 6];
                    next_st.f.dly_second = wd[`DCR_POS_DLY_SECOND +: 6];
                end
                `DCR_IDX_COARSE: begin
                    next_st.f.coarse_a = wd[`DCR_POS_COARSE_A +: 6];
                    next_st.f.coarse_b = wd[`DCR_POS_COARSE_B +: 6];
                end
                `DCR_IDX_FINE: begin
                    next_st.f.fine_a = wd[`DCR_POS_FINE_A +: 3];
                    next_st.f.fine_b = wd[`DCR_POS_FINE_B +: 3];
                    next_st.f.fine_ratio = wd[`DCR_POS_FINE_RATIO +: 3];
                end
                `DCR_IDX_FREQ_A_LO: next_st.f.freq_a_lo = wd;
                `DCR_IDX_FREQ_A_HI: next_st.f.freq_a_hi = wd;
                `DCR_IDX_FREQ_B_LO: next_st.f.freq_b_lo = wd;
                `DCR_IDX_FREQ_B_HI: next_st.f.freq_b_hi = wd;
                `DCR_IDX_PHASE_A:   next_st.f.phase_a = wd;
                `DCR_IDX_PHASE_B:   next_st.f.phase_b = wd;
                `DCR_IDX_MISC: begin
                    next_st.f.dither = wd[`DCR_POS_DITHER];
                end
                default: begin
                    next_st.f = st.f;
                end
            endcase
        end

        // Channel B is live only in dual narrowband mode
        next_st.b_active = next_st.f.dual_mode;

        // Programmable filter tap count per direction and length
        if (is_upconverter) begin
            next_st.pfir_taps = {3'h0, next_st.f.pfir_ctr, 1'b1};
        end else if (long_mode) begin
            next_st.pfir_taps = 9'({next_st.f.pfir_ctr, 3'h0} + 8'h08);
        end else begin
            next_st.pfir_taps = 9'({next_st.f.pfir_ctr, 2'h0} + 7'h04);
        end

        // Compensating filter tap count
        if (is_upconverter) begin
            next_st.cfir_taps = {1'b0, next_st.f.cfir_ctr, 1'b1};
        end else begin
            next_st.cfir_taps = 7'({next_st.f.cfir_ctr, 1'b0} + 6'h02);
        end

        // Filter scale exponents
        if (is_upconverter) begin
            next_st.pfir_exp = `DCR_EXP_PFIR_TX_BASE - {4'h0, next_st.f.pfir_gain[0]};
        end else begin
            next_st.pfir_exp = `DCR_EXP_PFIR_RX_BASE - {2'h0, next_st.f.pfir_gain};
        end
        next_st.cfir_exp = `DCR_EXP_CFIR_BASE - {4'h0, next_st.f.cfir_gain};

        // Comb shifts and section delays, B zeroed when idle
        next_st.cic_shift_a = next_st.f.shift_a;
        next_st.cic_shift_b = next_st.f.dual_mode ? next_st.f.shift_b : 5'h00;
        next_st.cic_ratio = 6'({1'b0, next_st.f.rate} + 6'h01);
        next_st.dly_double_a = next_st.f.dly_first;
        next_st.dly_double_b = next_st.f.dual_mode ? next_st.f.dly_second : 6'h00;

        // Coarse delay read address trails the write address
        next_st.coarse_rd_a = coarse_wr_a - next_st.f.coarse_a;
        next_st.coarse_rd_b = next_st.f.dual_mode ?
                              coarse_wr_b - next_st.f.coarse_b : coarse_wr_b;

        // Fine delay and shared ratio; code 0 stands for 8
        next_st.fine_dly_a = next_st.f.fine_a;
        next_st.fine_dly_b = next_st.f.dual_mode ? next_st.f.fine_b : 3'h0;
        next_st.fine_ratio_val = (next_st.f.fine_ratio == 3'h0) ?
                                 4'h8 : {1'b0, next_st.f.fine_ratio};

        // Oscillator accumulators and phase offset
        next_st.acc_a = st.acc_a + {st.f.freq_a_hi, st.f.freq_a_lo};
        next_st.acc_b = st.f.dual_mode ?
                        st.acc_b + {st.f.freq_b_hi, st.f.freq_b_lo} : 32'h0000_0000;
        next_st.phase_out_a = st.acc_a[31:16] + st.f.phase_a;
        next_st.phase_out_b = st.acc_b[31:16] + st.f.phase_b;
        next_st.dither_en = next_st.f.dither;
    end

    // State register
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st <= '0;
            st.f.dual_mode <= `DCR_RST_DUAL;
            st.f.rate <= `DCR_RST_RATE;
            st.f.fine_ratio <= `DCR_RST_FINE_RATIO;
            st.b_active <= `DCR_RST_DUAL;
            st.pfir_taps <= 9'h004;
            st.cfir_taps <= 7'h02;
            st.pfir_exp <= `DCR_EXP_PFIR_RX_BASE;
            st.cfir_exp <= `DCR_EXP_CFIR_BASE;
            st.cic_ratio <= 6'h19;
            st.fine_ratio_val <= 4'h1;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from the state register
    assign pready = st.pready;
    assign prdata = st.prdata;
    assign pslverr = st.pslverr;
    assign dual_mode = st.f.dual_mode;
    assign b_active = st.b_active;
    assign pfir_taps = st.pfir_taps;
    assign cfir_taps = st.cfir_taps;
    assign pfir_exp = st.pfir_exp;
    assign cfir_exp = st.cfir_exp;
    assign cic_shift_a = st.cic_shift_a;
    assign cic_shift_b = st.cic_shift_b;
    assign cic_ratio = st.cic_ratio;
    assign comb_delay_double_first = st.dly_double_a;
    assign comb_delay_double_second = st.dly_double_b;
    assign coarse_rd_a = st.coarse_rd_a;
    assign coarse_rd_b = st.coarse_rd_b;
    assign fine_dly_a = st.fine_dly_a;
    assign fine_dly_b = st.fine_dly_b;
    assign fine_ratio = st.fine_ratio_val;
    assign acc_a = st.acc_a;
    assign acc_b = st.acc_b;
    assign phase_out_a = st.phase_out_a;
    assign phase_out_b = st.phase_out_b;
    assign dither_en = st.dither_en;

endmodule // dcr_channel_regs

`default_nettype wire

// File: src/dcr_regs.svh
// Register offsets, field positions, reset values for the channel config block
`ifndef DCR_REGS_SVH
`define DCR_REGS_SVH

// Register indices; byte address is four times the index
`define DCR_IDX_MODE_TAP      8'h00
`define DCR_IDX_FILT_GAIN     8'h01
`define DCR_IDX_COMB_SHIFT    8'h0e
`define DCR_IDX_COMB_DELAY    8'h0f
`define DCR_IDX_COARSE        8'h11
`define DCR_IDX_FINE          8'h12
`define DCR_IDX_FREQ_A_LO     8'h13
`define DCR_IDX_FREQ_A_HI     8'h14
`define DCR_IDX_FREQ_B_LO     8'h15
`define DCR_IDX_FREQ_B_HI     8'h16
`define DCR_IDX_PHASE_A       8'h17
`define DCR_IDX_PHASE_B       8'h18
`define DCR_IDX_MISC          8'h19

// Field positions (lsb) within their 16-bit words
`define DCR_POS_DUAL          15
`define DCR_POS_PFIR_CTR      8
`define DCR_POS_CFIR_CTR      3
`define DCR_POS_PFIR_GAIN     13
`define DCR_POS_CFIR_GAIN     5
`define DCR_POS_SHIFT_A       11
`define DCR_POS_SHIFT_B       6
`define DCR_POS_RATE          0
`define DCR_POS_DLY_FIRST     10
`define DCR_POS_DLY_SECOND    4
`define DCR_POS_COARSE_A      10
`define DCR_POS_COARSE_B      4
`define DCR_POS_FINE_A        13
`define DCR_POS_FINE_B        10
`define DCR_POS_FINE_RATIO    7
`define DCR_POS_DITHER        15

// Reset values
`define DCR_RST_DUAL          1'h1
`define DCR_RST_RATE          5'h18
`define DCR_RST_FINE_RATIO    3'h1

// Scale exponents, magnitude of the power of two
`define DCR_EXP_PFIR_RX_BASE  5'h13
`define DCR_EXP_PFIR_TX_BASE  5'h12
`define DCR_EXP_CFIR_BASE     5'h13

`endif

// File: src/dcr_pkg.sv
// Types for the channel config register block
`default_nettype none
`include "dcr_regs.svh"

package dcr_pkg;

    typedef struct packed {
        logic        dual_mode;
        logic [4:0]  pfir_ctr;
        logic [4:0]  cfir_ctr;
        logic [2:0]  pfir_gain;
        logic        cfir_gain;
        logic [4:0]  shift_a;
        logic [4:0]  shift_b;
        logic [4:0]  rate;
        logic [5:0]  dly_first;
        logic [5:0]  dly_second;
        logic [5:0]  coarse_a;
        logic [5:0]  coarse_b;
        logic [2:0]  fine_a;
        logic [2:0]  fine_b;
        logic [2:0]  fine_ratio;
        logic [15:0] freq_a_lo;
        logic [15:0] freq_a_hi;
        logic [15:0] freq_b_lo;
        logic [15:0] freq_b_hi;
        logic [15:0] phase_a;
        logic [15:0] phase_b;
        logic        dither;
    } dcr_fields_s;

    typedef struct packed {
        dcr_fields_s f;
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
        logic        b_active;
        logic [8:0]  pfir_taps;
        logic [6:0]  cfir_taps;
        logic [4:0]  pfir_exp;
        logic [4:0]  cfir_exp;
        logic [4:0]  cic_shift_a;
        logic [4:0]  cic_shift_b;
        logic [5:0]  cic_ratio;
        logic [5:0]  dly_double_a;
        logic [5:0]  dly_double_b;
        logic [5:0]  coarse_rd_a;
        logic [5:0]  coarse_rd_b;
        logic [2:0]  fine_dly_a;
        logic [2:0]  fine_dly_b;
        logic [3:0]  fine_ratio_val;
        logic [31:0] acc_a;
        logic [31:0] acc_b;
        logic [15:0] phase_out_a;
        logic [15:0] phase_out_b;
        logic        dither_en;
    } dcr_state_s;

endpackage : dcr_pkg

`default_nettype wire

// File: verif/dcr_channel_regs_checker.sv
// Concurrent checks on the channel config register block ports
`default_nettype none

module dcr_channel_regs_checker
    import dcr_pkg::*;
(
    input wire logic        clk_sys,        // Clock
    input wire logic        rst_b,          // Reset, active low
    input wire logic        psel,           // Select
    input wire logic        penable,        // Enable
    input wire logic        pwrite,         // Direction
    input wire logic [7:0]  paddr,          // Byte address
    input wire logic [31:0] pwdata,         // Write data
    input wire logic        pready,         // Ready
    input wire logic [31:0] prdata,         // Read data
    input wire logic        pslverr,        // Error
    input wire logic        is_upconverter, // Transmit mode
    input wire logic        dual_mode,      // Dual mode
    input wire logic        b_active,       // Channel B in use
    input wire logic [8:0]  pfir_taps,      // Programmable taps
    input wire logic [6:0]  cfir_taps,      // Compensating taps
    input wire logic [4:0]  pfir_exp,       // Programmable scale
    input wire logic [5:0]  cic_ratio,      // Comb ratio
    input wire logic [3:0]  fine_ratio,     // Fine ratio
    input wire logic        dither_en,      // Dither on
    input wire logic [4:0]  cic_shift_b     // Comb shift B
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    logic [31:0] pw_q;
    logic        wr_go;

    // Write data of the previous cycle, for field compares
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) pw_q <= '0;
        else pw_q <= pwdata;
    end
    assign wr_go = psel && penable && pready && pwrite;

    pready_after_setup_a: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    pready_single_a: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    rdata_idle_zero_a: assert property (prdata[31:16] == 16'h0 && (pready || prdata == 32'h0))
        else $error("read data not zero");
    err_needs_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    dual_write_a: assert property (wr_go && paddr == 8'h00 |=> dual_mode == pw_q[15] && b_active == pw_q[15])
        else $error("dual mode not written");
    ratio_write_a: assert property (wr_go && paddr == 8'h38 |=> cic_ratio == {1'b0, pw_q[4:0]} + 6'h1)
        else $error("comb ratio wrong");
    fine_ratio_write_a: assert property (wr_go && paddr == 8'h48 |=> fine_ratio == ((pw_q[9:7] == 3'h0) ? 4'h8 : {1'b0, pw_q[9:7]}))
        else $error("fine ratio wrong");
    dither_write_a: assert property (wr_go && paddr == 8'h64 |=> dither_en == pw_q[15])
        else $error("dither enable wrong");
    up_taps_odd_a: assert property (is_upconverter |=> pfir_taps[0] && cfir_taps[0] && pfir_exp inside {5'h11, 5'h12})
        else $error("transmit taps or scale wrong");
    b_inert_a: assert property (!dual_mode |-> cic_shift_b == 5'h0)
        else $error("channel B shift active in single mode");

    // Main scenarios reached
    cover property (wr_go && paddr == 8'h00);
    cover property (pslverr);
    cover property (!dual_mode && is_upconverter);
endmodule // dcr_channel_regs_checker

`default_nettype wire

// File: verif/testbench.sv
// Self-checking bench for the channel config register block
`default_nettype none

module testbench;
    import dcr_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys, rst_b, psel, penable, pwrite, pready, pslverr;
    logic        is_upconverter, long_mode, dual_mode, b_active, dither_en;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, acc_a, acc_b;
    logic [5:0]  coarse_wr_a, coarse_wr_b, cic_ratio, coarse_rd_a, coarse_rd_b;
    logic [5:0]  comb_delay_double_first, comb_delay_double_second;
    logic [8:0]  pfir_taps;
    logic [6:0]  cfir_taps;
    logic [4:0]  pfir_exp, cfir_exp, cic_shift_a, cic_shift_b;
    logic [2:0]  fine_dly_a, fine_dly_b;
    logic [3:0]  fine_ratio;
    logic [15:0] phase_out_a, phase_out_b;
    int          num_errors, compares;
    // Register indices, readable masks and the config subset
    logic [7:0]  idx_t [13] = '{8'h00, 8'h01, 8'h0e, 8'h0f, 8'h11, 8'h12, 8'h13, 8'h14,
                                8'h15, 8'h16, 8'h17, 8'h18, 8'h19};
    logic [15:0] msk_t [13] = '{16'h9ff8, 16'he020, 16'hffdf, 16'hfff0, 16'hfff0, 16'hff80,
                                16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff, 16'hffff,
                                16'h8000};
    logic [7:0]  cf_t [7]   = '{8'h00, 8'h01, 8'h0e, 8'h0f, 8'h11, 8'h12, 8'h19};

    dcr_channel_regs i_dut (.clk_sys, .rst_b, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pready, .prdata, .pslverr, .is_upconverter, .long_mode, .coarse_wr_a, .coarse_wr_b,
        .dual_mode, .b_active, .pfir_taps, .cfir_taps, .pfir_exp, .cfir_exp, .cic_shift_a,
        .cic_shift_b, .cic_ratio, .comb_delay_double_first, .comb_delay_double_second,
        .coarse_rd_a, .coarse_rd_b, .fine_dly_a, .fine_dly_b, .fine_ratio, .acc_a, .acc_b,
        .phase_out_a, .phase_out_b, .dither_en);

    // Clock, 10 ns period
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Counts, verdict and end of run
    task automatic close_out();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Compare seen against expected
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One transfer; request held until ready is seen, no release so back-to-back works
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int n;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= {idx[5:0], 2'b00};
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(negedge clk_sys);
            if (pready === 1'b1) break;
        end
        if (n == 20) begin
            num_errors++;
            close_out();
        end
        rd  = prdata;
        err = pslverr;
        @(posedge clk_sys);
    endtask

    // Release the bus, then stop mid-cycle where outputs are settled
    task automatic idle(input int n);
        psel    <= 1'b0;
        penable <= 1'b0;
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask

    // Expected {pfir_taps, cfir_taps, pfir_exp, cfir_exp}
    function automatic logic [25:0] expect_filt(logic [15:0] w0, w1, logic up, lng);
        logic [8:0] p;
        p = up ? {3'h0, w0[12:8], 1'b1} : (({4'h0, w0[12:8]} + 9'h1) << (lng ? 3 : 2));
        return {p, up ? {1'b0, w0[7:3], 1'b1} : {1'b0, w0[7:3], 1'b0} + 7'h2,
                up ? 5'h12 - {4'h0, w1[13]} : 5'h13 - {2'h0, w1[15:13]},
                5'h13 - {4'h0, w1[5]}};
    endfunction

    // Main sequence
    initial begin
        logic [31:0] rd, v, pa, pb, sa, sb;
        logic [15:0] w [7];
        logic        er, up, lng, d;
        int          i, k;
        {rst_b, psel, penable, pwrite, is_upconverter, long_mode} = '0;
        {paddr, pwdata, coarse_wr_a, coarse_wr_b} = '0;
        num_errors = 0;
        compares = 0;
        repeat (6) @(posedge clk_sys);
        rst_b <= 1'b1;
        v = $urandom(1155);
        @(negedge clk_sys);
        chk("rst_ratio", cic_ratio, 32'd25);
        @(posedge clk_sys);
        // Reset values read back
        for (i = 0; i < 13; i++) begin
            apb(1'b0, idx_t[i], 32'h0, rd, er);
            chk("reset", rd, i == 0 ? 32'h8000 : i == 2 ? 32'h18 : i == 5 ? 32'h80 : 32'h0);
        end
        // Random write then read, back to back
        for (i = 0; i < 13; i++) begin
            v = $urandom;
            apb(1'b1, idx_t[i], v, rd, er);
            apb(1'b0, idx_t[i], 32'h0, rd, er);
            chk("readback", rd, {16'h0, v[15:0] & msk_t[i]});
            chk("pslverr", er, 32'h0);
        end
        // Unmapped index refused
        apb(1'b1, 8'h02, 32'hffff_ffff, rd, er);
        chk("unmapped_err", er, 32'h1);
        apb(1'b0, 8'h02, 32'h0, rd, er);
        chk("unmapped_rd", rd, 32'h0);
        // Field decode over the three filter modes, all-ones fields first
        for (i = 0; i < 24; i++) begin
            up  = (i % 3 == 0);
            lng = (i % 3 == 2);
            is_upconverter <= up;
            long_mode      <= lng;
            coarse_wr_a    <= 6'($urandom);
            coarse_wr_b    <= 6'($urandom);
            for (k = 0; k < 7; k++) begin
                w[k] = (i < 3) ? 16'hffff : 16'($urandom);
                if (up && k == 0) w[k] = w[k] | 16'h0108;
                apb(1'b1, cf_t[k], {16'h0, w[k]}, rd, er);
            end
            idle(1);
            d = w[0][15];
            v = 32'(expect_filt(w[0], w[1], up, lng));
            chk("dual_mode", dual_mode, d);
            chk("b_active", b_active, d);
            chk("pfir_taps", pfir_taps, v[25:17]);
            chk("cfir_taps", cfir_taps, v[16:10]);
            chk("pfir_exp", pfir_exp, v[9:5]);
            chk("cfir_exp", cfir_exp, v[4:0]);
            chk("shift_a", cic_shift_a, w[2][15:11]);
            chk("shift_b", cic_shift_b, d ? w[2][10:6] : 5'h0);
            chk("cic_ratio", cic_ratio, 6'(w[2][4:0] + 6'h1));
            chk("dly_first", comb_delay_double_first, w[3][15:10]);
            chk("dly_second", comb_delay_double_second, d ? w[3][9:4] : 6'h0);
            chk("coarse_a", coarse_rd_a, 6'(coarse_wr_a - w[4][15:10]));
            chk("coarse_b", coarse_rd_b, d ? 6'(coarse_wr_b - w[4][9:4]) : coarse_wr_b);
            chk("fine_a", fine_dly_a, w[5][15:13]);
            chk("fine_b", fine_dly_b, d ? w[5][12:10] : 3'h0);
            chk("fine_ratio", fine_ratio, w[5][9:7] == 3'h0 ? 4'h8 : {1'b0, w[5][9:7]});
            chk("dither", dither_en, w[6][15]);
            @(posedge clk_sys);
        end
        // Accumulators and phase offset in dual mode, then channel B idle
        pa = $urandom;
        pb = $urandom;
        v  = $urandom;
        for (k = 0; k < 6; k++) begin
            rd = (k < 2) ? pa : (k < 4) ? pb : v;
            apb(1'b1, 8'h13 + 8'(k), {16'h0, k[0] ? rd[31:16] : rd[15:0]}, rd, er);
        end
        apb(1'b1, 8'h00, 32'h8000, rd, er);
        idle(3);
        sa = acc_a;
        sb = acc_b;
        @(negedge clk_sys);
        chk("acc_a", acc_a, sa + pa);
        chk("acc_b", acc_b, sb + pb);
        chk("phase_a", phase_out_a, 16'(sa[31:16] + v[15:0]));
        chk("phase_b", phase_out_b, 16'(sb[31:16] + v[31:16]));
        @(posedge clk_sys);
        apb(1'b1, 8'h00, 32'h0, rd, er);
        idle(2);
        chk("acc_b_off", acc_b, 32'h0);
        close_out();
    end
endmodule // testbench

bind dcr_channel_regs dcr_channel_regs_checker i_chk (.clk_sys, .rst_b, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .prdata, .pslverr, .is_upconverter, .dual_mode,
    .b_active, .pfir_taps, .cfir_taps, .pfir_exp, .cic_ratio, .fine_ratio, .dither_en,
    .cic_shift_b);

`default_nettype wire
